// ==== bench/pcd_pin_source.sv ====
/*
 Model of the outside world on the port pins: levels set by the bench.
 Assumes the bench updates goal and wiggle just after a rising mclk edge.
*/
`timescale 1ns/1ps
module pcd_pin_source
  import pcd_pkg::*;
#(
  parameter int WIDTH = 24
)(
  input wire logic mclk,
  input wire logic [WIDTH-1:0] goal,
  input wire logic [1:0] lag,
  input wire logic [WIDTH-1:0] wiggle,
  output logic [WIDTH-1:0] pins
);
  logic [WIDTH-1:0] stage_reg [3] = '{default: '0};
  logic toggle_reg = 1'b0;
  logic [WIDTH-1:0] level;
  // Slow sources lag the requested level by up to three cycles
  always @(posedge mclk) begin
    stage_reg[0] <= goal;
    stage_reg[1] <= stage_reg[0];
    stage_reg[2] <= stage_reg[1];
    toggle_reg <= ~toggle_reg;
  end
  assign level = (lag == 2'd0) ? goal : stage_reg[lag - 2'd1];
  // Skewed from mclk: pins are asynchronous to the device
  assign #3 pins = level ^ (wiggle & {WIDTH{toggle_reg}});
endmodule : pcd_pin_source

// ==== bench/test_pin_change_interrupt.sv ====
/*
 Self-checking bench: AXI4-Lite register tasks plus pin stimulus.
 Assumes the default of three ports and the register map of pcd_pkg.
*/
`timescale 1ns/1ps
module test_pin_change_interrupt;
  import pcd_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic core_asleep = 1'b0;
  logic [23:0] goal = '0;
  logic [23:0] wiggle = '0;
  logic [1:0] lag = 2'd0;
  logic [23:0] pins;
  logic change_irq, wake_core;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int bad_count = 0;
  int checks_done = 0;

  always #5 mclk = ~mclk;

  pcd_pin_source #(.WIDTH(24)) partner (.mclk(mclk), .goal(goal),
    .lag(lag), .wiggle(wiggle), .pins(pins));

  pcd_pin_change #(.NUM_PORTS(3)) dut (.mclk(mclk), .reset(reset),
    .port_pins(pins), .core_asleep(core_asleep),
    .change_irq(change_irq), .wake_core(wake_core),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  task automatic close_out();
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_t, w_t;
    int n;
    aw_t = 1'b0;
    w_t = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (!aw_t && awready) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_t && wready) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    check({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arready) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    check(rdata, e);
    check({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
  endtask : rd

  task automatic reset_checks();
    for (int p = 0; p < 3; p++) begin
      rd(8'(p * 16) + PCD_RISE_OFS, 32'h0, PCD_RESP_OKAY);
      rd(8'(p * 16) + PCD_FALL_OFS, 32'h0, PCD_RESP_OKAY);
      rd(8'(p * 16) + PCD_FLAG_OFS, 32'h0, PCD_RESP_OKAY);
    end
    rd(PCD_CTRL_ADDR, 32'h0, PCD_RESP_OKAY);
  endtask : reset_checks

  initial begin
    #50_000;
    bad_count++;
    close_out();
  end

  initial begin
    tick(5);
    reset <= 1'b0;
    tick(1);
    reset_checks();
    rd(8'h0c, 32'h0, PCD_RESP_SLVERR);
    wr(8'h84, 32'h1, 4'hf, PCD_RESP_SLVERR);
    // Upper data bits are dropped on write and read back as zero
    wr(8'h00, 32'hffff_ff05, 4'hf, PCD_RESP_OKAY);
    rd(8'h00, 32'h05, PCD_RESP_OKAY);
    wr(8'h04, 32'h06, 4'hf, PCD_RESP_OKAY);
    wr(8'h04, 32'hff, 4'h0, PCD_RESP_OKAY);
    rd(8'h04, 32'h06, PCD_RESP_OKAY);
    wr(8'h20, 32'h80, 4'hf, PCD_RESP_OKAY);
    lag <= 2'd3;
    goal <= 24'h80_0007;
    tick(10);
    check({31'h0, change_irq}, 32'h0);
    rd(8'h08, 32'h05, PCD_RESP_OKAY);
    rd(8'h28, 32'h80, PCD_RESP_OKAY);
    rd(PCD_CTRL_ADDR, 32'h2, PCD_RESP_OKAY);
    wr(PCD_CTRL_ADDR, 32'h1, 4'hf, PCD_RESP_OKAY);
    tick(3);
    check({30'h0, change_irq, wake_core}, 32'h2);
    // Clear only the bits known to be set, as software should
    wr(8'h08, 32'h05 & ~32'h05, 4'hf, PCD_RESP_OKAY);
    rd(8'h08, 32'h0, PCD_RESP_OKAY);
    rd(PCD_CTRL_ADDR, 32'h3, PCD_RESP_OKAY);
    wr(8'h28, 32'h0, 4'hf, PCD_RESP_OKAY);
    tick(3);
    check({31'h0, change_irq}, 32'h0);
    lag <= 2'd0;
    goal <= 24'h0;
    tick(10);
    rd(8'h08, 32'h06, PCD_RESP_OKAY);
    rd(8'h28, 32'h0, PCD_RESP_OKAY);
    wr(8'h08, 32'h0, 4'hf, PCD_RESP_OKAY);
    core_asleep <= 1'b1;
    tick(4);
    goal <= 24'h1;
    tick(10);
    check({30'h0, change_irq, wake_core}, 32'h3);
    rd(8'h08, 32'h01, PCD_RESP_OKAY);
    rd(PCD_CTRL_ADDR, 32'h7, PCD_RESP_OKAY);
    wr(8'h08, 32'h0, 4'hf, PCD_RESP_OKAY);
    core_asleep <= 1'b0;
    // Edge every cycle, so one lands on the clearing write itself
    wiggle <= 24'h4;
    tick(4);
    wr(8'h08, 32'h0, 4'hf, PCD_RESP_OKAY);
    rd(8'h08, 32'h04, PCD_RESP_OKAY);
    wiggle <= 24'h0;
    tick(8);
    wr(8'h08, 32'h0, 4'hf, PCD_RESP_OKAY);
    rd(8'h08, 32'h0, PCD_RESP_OKAY);
    reset <= 1'b1;
    tick(5);
    reset <= 1'b0;
    tick(1);
    goal <= 24'h0;
    reset_checks();
    close_out();
  end
endmodule : test_pin_change_interrupt

// ==== design/pcd_pin_change.sv ====
/*
 Pin change detection top: per-port edge enables and change flags,
 summary flag, master enable, interrupt and wake outputs, AXI4-Lite slave.
 Assumes pins asynchronous to mclk and mclk kept running in Sleep.
*/
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// How it works
// RL1: Every pin of every port can be set to detect changes, alone or combined.
// RL2: Each pin has its own rising and falling edge detector.
// RL3: A set bit of the port's rise enable register arms rising edges.
// RL4: A set bit of the port's fall enable register arms falling edges.
// RL5: Both bits set make a pin catch edges in either direction.
// RL6: Flags still set with the master enable clear, but no interrupt is raised.
// RL7: An armed edge on a pin sets that pin's change flag.
// RL8: The summary flag is the OR of all change flags of all ports.
// RL9: Software clears single change flags by writing zero to them.
// RL10: An edge during a clearing write leaves its flag set regardless.
// RL11: Software should clear flags by AND-ing out known bits only.
// RL12: A detected armed change wakes the core when the master enable is set.
// RL13: A flag caught in Sleep is set before the core runs after waking.
// RL14: Each port has an eight-bit rise enable register reset to zero.
// RL15: Each port has an eight-bit change flag register reset to zero.
// RL16: Each pin is synchronised and edges found by comparing two samples.
// RL17: In Sleep edges are seen on a retained clock so wake needs no core clock.
module pcd_pin_change
  import pcd_pkg::*;
#(
  parameter int NUM_PORTS = 3
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [NUM_PORTS*PCD_PIN_W-1:0] port_pins,
  input wire logic core_asleep,
  output logic change_irq,
  output logic wake_core,
  input wire logic [PCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [PCD_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [PCD_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NPIN = NUM_PORTS * PCD_PIN_W;

  logic [NPIN-1:0] rise_edge_enable_reg;
  logic [NPIN-1:0] fall_edge_enable_reg;
  logic [NPIN-1:0] pin_change_flag_reg;
  logic [NPIN-1:0] edge_hits;
  logic [NPIN-1:0] flag_wr;
  logic change_irq_master_enable;
  logic change_summary_flag;
  logic asleep_s1_reg;
  logic asleep_s2_reg;

  logic [PCD_ADDR_W-1:0] awaddr_reg;
  logic [PCD_DATA_W-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [PCD_DATA_W-1:0] rd_word;

  // Sleep request comes from another domain
  always_ff @(posedge mclk) begin
    if (reset) begin
      asleep_s1_reg <= 1'b0;
      asleep_s2_reg <= 1'b0;
    end else begin
      asleep_s1_reg <= core_asleep;
      asleep_s2_reg <= asleep_s1_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      pcd_pin_edge u_pin (
        .mclk(mclk),
        .reset(reset),
        .pin_in(port_pins[gi]),
        .rise_en(rise_edge_enable_reg[gi]),
        .fall_en(fall_edge_enable_reg[gi]),
        .flag_wr(flag_wr[gi]),
        .flag_wdata(wdata_reg[gi % PCD_PIN_W]),
        .flag(pin_change_flag_reg[gi]),
        .edge_hit(edge_hits[gi])
      ); // RL1 RL2 RL16 RL17
    end
  endgenerate

  assign change_summary_flag = |pin_change_flag_reg; // RL8

  // Write channel: take address and data in either order
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Decode for writes; only byte lane 0 carries register bits
  always_comb begin
    flag_wr = '0;
    wr_hit = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (awaddr_reg == 8'(p * PCD_PORT_STRIDE) + PCD_RISE_OFS) begin
        wr_hit = 1'b1;
      end else if (awaddr_reg == 8'(p * PCD_PORT_STRIDE) + PCD_FALL_OFS) begin
        wr_hit = 1'b1;
      end else if (awaddr_reg == 8'(p * PCD_PORT_STRIDE) + PCD_FLAG_OFS) begin
        wr_hit = 1'b1;
        if (do_write && wstrb_reg[0]) begin
          flag_wr[p*PCD_PIN_W +: PCD_PIN_W] = '1; // RL9
        end
      end
    end
    if (awaddr_reg == PCD_CTRL_ADDR) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rise_edge_enable_reg <= {NUM_PORTS{PCD_EN_RESET}}; // RL14
      fall_edge_enable_reg <= {NUM_PORTS{PCD_EN_RESET}};
    end else if (do_write && wstrb_reg[0]) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (awaddr_reg == 8'(p * PCD_PORT_STRIDE) + PCD_RISE_OFS) begin
          rise_edge_enable_reg[p*PCD_PIN_W +: PCD_PIN_W] <=
            wdata_reg[PCD_PIN_W-1:0]; // RL3
        end else if (awaddr_reg == 8'(p * PCD_PORT_STRIDE) + PCD_FALL_OFS)
        begin
          fall_edge_enable_reg[p*PCD_PIN_W +: PCD_PIN_W] <=
            wdata_reg[PCD_PIN_W-1:0]; // RL4
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      change_irq_master_enable <= 1'b0;
    end else if (do_write && wstrb_reg[0] && awaddr_reg == PCD_CTRL_ADDR) begin
      change_irq_master_enable <= wdata_reg[PCD_CTRL_MIE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCD_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? PCD_RESP_OKAY : PCD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side
  always_comb begin
    rd_word = PCD_ZERO_WORD;
    rd_hit = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (s_axi_araddr == 8'(p * PCD_PORT_STRIDE) + PCD_RISE_OFS) begin
        rd_hit = 1'b1;
        rd_word[PCD_PIN_W-1:0] =
          rise_edge_enable_reg[p*PCD_PIN_W +: PCD_PIN_W];
      end else if (s_axi_araddr == 8'(p * PCD_PORT_STRIDE) + PCD_FALL_OFS)
      begin
        rd_hit = 1'b1;
        rd_word[PCD_PIN_W-1:0] =
          fall_edge_enable_reg[p*PCD_PIN_W +: PCD_PIN_W];
      end else if (s_axi_araddr == 8'(p * PCD_PORT_STRIDE) + PCD_FLAG_OFS)
      begin
        rd_hit = 1'b1;
        rd_word[PCD_PIN_W-1:0] = pin_change_flag_reg[p*PCD_PIN_W +: PCD_PIN_W];
      end
    end
    if (s_axi_araddr == PCD_CTRL_ADDR) begin
      rd_hit = 1'b1;
      rd_word[PCD_CTRL_MIE_BIT] = change_irq_master_enable;
      rd_word[PCD_CTRL_SUM_BIT] = change_summary_flag; // RL8
      rd_word[PCD_CTRL_SLEEP_BIT] = asleep_s2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= PCD_ZERO_WORD;
      s_axi_rresp <= PCD_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? PCD_RESP_OKAY : PCD_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Interrupt follows the flags, gated by the master enable
  always_ff @(posedge mclk) begin
    if (reset) begin
      change_irq <= 1'b0;
      wake_core <= 1'b0;
    end else begin
      change_irq <= change_irq_master_enable && change_summary_flag; // RL6
      // Flag is already set when wake rises, so it precedes the first fetch
      wake_core <= change_irq_master_enable && asleep_s2_reg &&
        change_summary_flag; // RL12 RL13
    end
  end

  property p_irq_gated;
    @(posedge mclk) disable iff (reset)
      !change_irq_master_enable |=> !change_irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated) // RL6
    else $error("interrupt raised with master enable clear");
  property p_irq_follows;
    @(posedge mclk) disable iff (reset)
      (change_irq_master_enable && change_summary_flag) |=> change_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // RL6
    else $error("interrupt missing");
  property p_flag_without_enable;
    @(posedge mclk) disable iff (reset)
      (|edge_hits && !change_irq_master_enable) |=> change_summary_flag;
  endproperty
  a_flag_without_enable: assert property (p_flag_without_enable) // RL6
    else $error("flag not set while master enable clear");
  // Checks the OR as software sees it through a control read
  property p_summary_or;
    @(posedge mclk) disable iff (reset)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == PCD_CTRL_ADDR)
        |=> s_axi_rdata[PCD_CTRL_SUM_BIT] ==
          ($past(pin_change_flag_reg) != '0);
  endproperty
  a_summary_or: assert property (p_summary_or) // RL8
    else $error("summary flag differs from OR of flags");
  property p_wake;
    @(posedge mclk) disable iff (reset)
      wake_core |-> ($past(change_summary_flag) &&
        $past(change_irq_master_enable));
  endproperty
  a_wake: assert property (p_wake) // RL12 RL13
    else $error("wake without enabled flag");
  property p_enable_reset;
    @(posedge mclk) $fell(reset) |-> rise_edge_enable_reg == '0;
  endproperty
  a_enable_reset: assert property (p_enable_reset) // RL14
    else $error("rise enables not zero after reset");
  property p_flag_reset;
    @(posedge mclk) $fell(reset) |-> pin_change_flag_reg == '0;
  endproperty
  a_flag_reset: assert property (p_flag_reset) // RL15
    else $error("flags not zero after reset");
  property p_no_spurious;
    @(posedge mclk) disable iff (reset)
      (!change_summary_flag && edge_hits == '0 && !do_write)
        |=> !change_summary_flag;
  endproperty
  a_no_spurious: assert property (p_no_spurious) // RL7
    else $error("flag set without edge");
  property p_bresp_within;
    @(posedge mclk) disable iff (reset) do_write |=> s_axi_bvalid;
  endproperty
  a_bresp_within: assert property (p_bresp_within)
    else $error("write response missing");

  c_irq: cover property (@(posedge mclk) disable iff (reset) $rose(change_irq));
  c_wake: cover property (@(posedge mclk) disable iff (reset) $rose(wake_core));
  c_race: cover property (@(posedge mclk) disable iff (reset)
    (|(edge_hits & flag_wr)));
  c_quiet_flag: cover property (@(posedge mclk) disable iff (reset)
    change_summary_flag && !change_irq_master_enable);
endmodule : pcd_pin_change

// ==== design/pcd_pin_edge.sv ====
/*
 One pin's synchroniser and edge detector, with its sticky change flag.
 Assumes the pin is asynchronous to mclk; flag writes come as one-cycle
 strobes from the register slave on mclk.
*/
`timescale 1ns/1ps
module pcd_pin_edge
  import pcd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic pin_in,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic flag_wr,
  input wire logic flag_wdata,
  output logic flag,
  output logic edge_hit
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rise_hit;
  logic fall_hit;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise_hit = rise_en & sync2_reg & ~prev_reg; // RL2 RL3 RL16
  assign fall_hit = fall_en & ~sync2_reg & prev_reg; // RL2 RL4 RL16
  assign edge_hit = rise_hit | fall_hit; // RL5

  // Set wins over a write in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      flag <= 1'b0; // RL15
    end else if (edge_hit) begin
      flag <= 1'b1; // RL7 RL10
    end else if (flag_wr) begin
      flag <= flag_wdata; // RL9
    end
  end

  property p_edge_sets_flag;
    @(posedge mclk) disable iff (reset)
      edge_hit |=> flag;
  endproperty
  a_edge_sets_flag: assert property (p_edge_sets_flag) // RL7
    else $error("edge did not set flag");
  property p_clear_takes;
    @(posedge mclk) disable iff (reset)
      (flag_wr && !edge_hit) |=> (flag == $past(flag_wdata));
  endproperty
  a_clear_takes: assert property (p_clear_takes) // RL9
    else $error("flag write did not take the written value");
  property p_set_beats_clear;
    @(posedge mclk) disable iff (reset)
      (edge_hit && flag_wr && !flag_wdata) |=> flag;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // RL10
    else $error("clear beat a new edge");
endmodule : pcd_pin_edge

// ==== include/pcd_pkg.sv ====
/*
 Package for the pin change detection block: register map, field
 positions, reset values and bus answer codes.
 Assumes AXI4-Lite with 32-bit data, one aligned word per register.
*/
package pcd_pkg;
  localparam int PCD_PIN_W = 8;
  localparam int PCD_ADDR_W = 8;
  localparam int PCD_DATA_W = 32;
  localparam int PCD_SYNC_STAGES = 2;
  // Per-port block: rise enable, fall enable, flags
  localparam logic [7:0] PCD_PORT_STRIDE = 8'h10;
  localparam logic [7:0] PCD_RISE_OFS = 8'h00;
  localparam logic [7:0] PCD_FALL_OFS = 8'h04;
  localparam logic [7:0] PCD_FLAG_OFS = 8'h08;
  localparam logic [7:0] PCD_CTRL_ADDR = 8'h80;
  localparam int PCD_CTRL_MIE_BIT = 0;
  localparam int PCD_CTRL_SUM_BIT = 1;
  localparam int PCD_CTRL_SLEEP_BIT = 2;
  localparam logic [7:0] PCD_EN_RESET = 8'h00;
  localparam logic [7:0] PCD_FLAG_RESET = 8'h00;
  localparam logic [1:0] PCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCD_RESP_SLVERR = 2'h2;
  localparam logic [31:0] PCD_ZERO_WORD = 32'h0000_0000;
endpackage : pcd_pkg
